//--- data_eeprom_access_control_tb.sv
// Purpose: self checking bench for dea_ctrl
// Assumes: ADDR_BITS 5, ce dropped once to check freezing
// Notes: start pulses are counted
`timescale 1ns/1ps
module data_eeprom_access_control_tb;
    reg clk, nrst, ce, reg_wr, reg_rd, arr_prog_done, arr_fetch_done;
    reg [1:0] reg_sel;
    reg [7:0] reg_wdata, arr_rdata;
    wire [7:0] reg_rdata, arr_addr, arr_wdata;
    wire arr_prog_start, arr_fetch_start, nvm_done_flag;
    integer bad_count = 0, num_checks = 0, n_prog = 0, n_fetch = 0;
    dea_ctrl #(.ADDR_BITS(5)) uut (.clk(clk), .nrst(nrst), .ce(ce),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_prog_start(arr_prog_start),
        .arr_fetch_start(arr_fetch_start), .arr_prog_done(arr_prog_done),
        .arr_fetch_done(arr_fetch_done), .arr_rdata(arr_rdata),
        .nvm_done_flag(nvm_done_flag));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        n_prog <= n_prog + arr_prog_start;
        n_fetch <= n_fetch + arr_fetch_start;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [1:0] s, input [7:0] d);
        begin
            @(posedge clk) #1;
            reg_sel = s;
            reg_wdata = d;
            reg_wr = 1;
            @(posedge clk) #1;
            reg_wr = 0;
        end
    endtask
    task rd(input [1:0] s, input [7:0] exp);
        begin
            @(posedge clk) #1;
            reg_sel = s;
            reg_rd = 1;
            @(posedge clk) #1;
            reg_rd = 0;
            chk(reg_rdata, exp);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task t_addr;
        begin
            rd(2'h2, 8'h00);
            wr(2'h0, 8'hff);
            rd(2'h0, 8'h1f);
            wr(2'h0, 8'h15);
        end
    endtask
    task t_prog;
        begin
            wr(2'h2, 8'h04);
            rd(2'h2, 8'h00);
            wr(2'h1, 8'h5a);
            wr(2'h2, 8'h08);
            wr(2'h2, 8'h0c);
            rd(2'h2, 8'h0c);
            chk(n_prog[7:0], 8'h01);
            chk(arr_addr, 8'h15);
            chk(arr_wdata, 8'h5a);
            arr_prog_done = 1;
            repeat (6) @(posedge clk);
            rd(2'h2, 8'h08);
            rd(2'h3, 8'h01);
            chk({7'h00, nvm_done_flag}, 8'h01);
            wr(2'h3, 8'h00);
            rd(2'h3, 8'h00);
            chk({7'h00, nvm_done_flag}, 8'h00);
        end
    endtask
    task t_fetch;
        begin
            wr(2'h2, 8'h00);
            arr_prog_done = 0;
            wr(2'h2, 8'h01);
            rd(2'h2, 8'h00);
            chk(n_fetch[7:0], 8'h00);
            wr(2'h2, 8'h02);
            wr(2'h2, 8'h03);
            rd(2'h2, 8'h03);
            chk(n_fetch[7:0], 8'h01);
            arr_rdata = 8'hc3;
            arr_fetch_done = 1;
            @(posedge clk) #1;
            arr_fetch_done = 0;
            arr_rdata = 8'h3c;
            rd(2'h2, 8'h02);
            rd(2'h1, 8'hc3);
        end
    endtask
    task t_freeze;
        begin
            @(posedge clk) #1;
            ce = 0;
            wr(2'h0, 8'h0a);
            ce = 1;
            rd(2'h0, 8'h15);
        end
    endtask
    initial begin
        {ce, nrst, reg_wr, reg_rd, arr_prog_done, arr_fetch_done} = 6'h20;
        reg_sel = 2'h0;
        reg_wdata = 8'h00;
        arr_rdata = 8'h3c;
        repeat (4) @(posedge clk);
        #1 nrst = 1;
        t_addr;
        t_prog;
        t_fetch;
        t_freeze;
        conclude;
    end
    initial begin
        #100000;
        bad_count = bad_count + 1;
        conclude;
    end
endmodule

//--- dea_ctrl.v
// Purpose: byte access control for an on-chip data nonvolatile array
// Assumes: byte register port, array timer runs on its own clock
// Notes: array done flag is a level held until software writes it zero
// How it works
// - Address width set by variant parameter
// - Unimplemented address and control bits read zero
// - Programming only while program enable set
// - Program start runs cycle, self clears
// - Program start reads zero when idle
// - Program start ignored without prior enable
// - Fetch only while fetch enable set
// - Fetch start runs cycle, self clears
// - Fetch start ignored without prior enable
// - Fetched byte held in data register
// - Program cycle timed by asynchronous timer
// - Program end sets software cleared flag
`timescale 1ns/1ps
`include "dea_regs.vh"
module dea_ctrl #(
    parameter ADDR_BITS = `DEA_ADDR_BITS_DEF
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    input wire ce,
    // Register port
    input wire [1:0] reg_sel,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Array side
    output reg [7:0] arr_addr,
    output reg [7:0] arr_wdata,
    output reg arr_prog_start,
    output reg arr_fetch_start,
    input wire arr_prog_done,
    input wire arr_fetch_done,
    input wire [7:0] arr_rdata,
    // Done request
    output reg nvm_done_flag
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PROG = 2'h1;
    localparam ST_FETCH = 2'h2;

    reg [7:0] cell_address_reg;
    reg [7:0] nvm_data_reg;
    reg program_enable;
    reg prog_start;
    reg fetch_enable;
    reg fetch_start;
    reg [1:0] state;
    reg [1:0] next_state;
    wire prog_done_s;
    wire prog_done_rise;
    wire [7:0] addr_mask;

    function [7:0] mask_of;
        input integer bits;
        begin
            mask_of = 8'hff >> (8 - bits);
        end
    endfunction

    assign addr_mask = mask_of(ADDR_BITS);

    // Programming timer lives in another domain
    dea_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .din(arr_prog_done),
        .dout(prog_done_s)
    );

    dea_edge u_edge (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .lvl(prog_done_s),
        .rise(prog_done_rise)
    );

    // Write strobe aimed at one register
    function sel_hit;
        input wr;
        input [1:0] sel;
        input [1:0] want;
        begin
            sel_hit = wr && (sel == want);
        end
    endfunction

    // Write decode
    wire wr_addr;
    wire wr_data;
    wire wr_ctrl;
    wire wr_flag;

    // Cycle events
    wire idle;
    wire set_prog;
    wire set_fetch;
    wire prog_end;
    wire fetch_end;

    // Next values
    reg next_program_enable;
    reg next_fetch_enable;
    reg next_prog_start;
    reg next_fetch_start;
    reg next_flag;
    reg [7:0] next_rdata;

    assign wr_addr = sel_hit(reg_wr, reg_sel, `DEA_SEL_ADDR);
    assign wr_data = sel_hit(reg_wr, reg_sel, `DEA_SEL_DATA);
    assign wr_ctrl = sel_hit(reg_wr, reg_sel, `DEA_SEL_CTRL);
    assign wr_flag = sel_hit(reg_wr, reg_sel, `DEA_SEL_FLAG);
    assign idle = (state == ST_IDLE);

    // Start only with enable already set
    assign set_prog = wr_ctrl && reg_wdata[`DEA_BIT_PROG_START]
        && program_enable && idle;
    assign set_fetch = wr_ctrl && reg_wdata[`DEA_BIT_FETCH_START]
        && fetch_enable && idle && !set_prog;
    assign prog_end = (state == ST_PROG) && prog_done_rise;
    assign fetch_end = (state == ST_FETCH) && arr_fetch_done;

    // Cycle sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (set_prog) begin
                    next_state = ST_PROG;
                end else if (set_fetch) begin
                    next_state = ST_FETCH;
                end
            end
            ST_PROG: begin
                if (prog_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FETCH: begin
                if (fetch_end) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Enables follow any control write
    always @* begin
        next_program_enable = program_enable;
        next_fetch_enable = fetch_enable;
        if (wr_ctrl) begin
            next_program_enable = reg_wdata[`DEA_BIT_PROG_EN];
            next_fetch_enable = reg_wdata[`DEA_BIT_FETCH_EN];
        end
    end

    // Program start set by software, cleared at end
    always @* begin
        next_prog_start = prog_start;
        if (set_prog) begin
            next_prog_start = 1'b1;
        end else if (prog_end) begin
            next_prog_start = 1'b0;
        end
    end

    // Fetch start set by software, cleared at end
    always @* begin
        next_fetch_start = fetch_start;
        if (set_fetch) begin
            next_fetch_start = 1'b1;
        end else if (fetch_end) begin
            next_fetch_start = 1'b0;
        end
    end

    // Set wins over software clear
    always @* begin
        next_flag = nvm_done_flag;
        if (prog_end) begin
            next_flag = 1'b1;
        end else if (wr_flag && !reg_wdata[0]) begin
            next_flag = 1'b0;
        end
    end

    // State
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Enable bits
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            program_enable <= 1'b0;
            fetch_enable <= 1'b0;
        end else if (ce) begin
            program_enable <= next_program_enable;
            fetch_enable <= next_fetch_enable;
        end
    end

    // Start bits
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_start <= 1'b0;
            fetch_start <= 1'b0;
        end else if (ce) begin
            prog_start <= next_prog_start;
            fetch_start <= next_fetch_start;
        end
    end

    // One cycle start pulses to the array
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arr_prog_start <= 1'b0;
            arr_fetch_start <= 1'b0;
        end else if (ce) begin
            arr_prog_start <= set_prog;
            arr_fetch_start <= set_fetch;
        end
    end

    // Done flag
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nvm_done_flag <= 1'b0;
        end else if (ce) begin
            nvm_done_flag <= next_flag;
        end
    end

    // Address register, no reset
    always @(posedge clk) begin
        if (ce) begin
            if (wr_addr) begin
                cell_address_reg <= reg_wdata & addr_mask;
            end
        end
    end

    // Data register, no reset
    always @(posedge clk) begin
        if (ce) begin
            if (fetch_end) begin
                nvm_data_reg <= arr_rdata;
            end else if (wr_data && idle) begin
                nvm_data_reg <= reg_wdata;
            end
        end
    end

    // Address and data latched at cycle start
    always @(posedge clk) begin
        if (ce) begin
            if (set_prog || set_fetch) begin
                arr_addr <= cell_address_reg;
                arr_wdata <= nvm_data_reg;
            end
        end
    end

    // Read view of the selected register
    always @* begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_sel)
                `DEA_SEL_ADDR: begin
                    next_rdata = cell_address_reg & addr_mask;
                end
                `DEA_SEL_DATA: begin
                    next_rdata = nvm_data_reg;
                end
                `DEA_SEL_CTRL: begin
                    next_rdata = {4'h0, program_enable, prog_start,
                        fetch_enable, fetch_start};
                end
                `DEA_SEL_FLAG: begin
                    next_rdata = {7'h00, nvm_done_flag};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Read data holds until the next read
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

//--- dea_ctrl_monitor.sv
// Purpose: port assertions for dea_ctrl
// Assumes: one clock, nrst async low
// Notes: bound into every dea_ctrl
`timescale 1ns/1ps
module dea_mon #(
    parameter ADDR_BITS = 8
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    input wire ce,
    // Register port
    input wire [1:0] reg_sel,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Array side
    input wire [7:0] arr_addr,
    input wire arr_prog_start,
    input wire arr_fetch_start,
    input wire arr_prog_done,
    input wire nvm_done_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_one_start: assert property (arr_prog_start |-> !arr_fetch_start)
        else $error("two starts");
    a_prog_pulse: assert property (arr_prog_start && ce |=> !arr_prog_start)
        else $error("long prog start");
    a_fetch_pulse: assert property (
        arr_fetch_start && ce |=> !arr_fetch_start)
        else $error("long fetch start");
    a_addr_hold: assert property (
        arr_prog_start |=> $stable(arr_addr) [*3])
        else $error("address moved");
    a_flag_cause: assert property ($rose(nvm_done_flag) |-> arr_prog_done)
        else $error("flag without end");
    a_flag_held: assert property (
        nvm_done_flag && !reg_wr |=> nvm_done_flag)
        else $error("flag lost");
    a_ctrl_zero: assert property (
        reg_rd && reg_sel == 2'h2 |=> reg_rdata[7:4] == 4'h0)
        else $error("ctrl upper set");
    a_addr_zero: assert property (
        reg_rd && reg_sel == 2'h0 |=> (reg_rdata >> ADDR_BITS) == 8'h0)
        else $error("addr upper set");
endmodule
bind dea_ctrl dea_mon #(.ADDR_BITS(ADDR_BITS)) u_mon (.clk(clk), .nrst(nrst),
    .ce(ce),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .arr_addr(arr_addr),
    .arr_prog_start(arr_prog_start), .arr_fetch_start(arr_fetch_start),
    .arr_prog_done(arr_prog_done), .nvm_done_flag(nvm_done_flag));

//--- dea_edge.v
// Purpose: rising edge pulse of a synchronised level
// Assumes: input already synchronous
// Notes: one cycle pulse
`timescale 1ns/1ps
module dea_edge (
    // Clock and reset
    input wire clk,
    input wire nrst,
    input wire ce,
    // Level in, pulse out
    input wire lvl,
    output wire rise
);
    reg last;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last <= 1'b0;
        end else if (ce) begin
            last <= lvl;
        end
    end
    assign rise = lvl & ~last & ce;
endmodule

//--- dea_regs.vh
// Purpose: constants for the data nonvolatile access control block
// Assumes: one byte wide register port
// Notes: register selects are local to this block
`ifndef DEA_REGS_VH
`define DEA_REGS_VH
`define DEA_SEL_ADDR 2'h0
`define DEA_SEL_DATA 2'h1
`define DEA_SEL_CTRL 2'h2
`define DEA_SEL_FLAG 2'h3
`define DEA_BIT_FETCH_START 0
`define DEA_BIT_FETCH_EN 1
`define DEA_BIT_PROG_START 2
`define DEA_BIT_PROG_EN 3
`define DEA_CTRL_RESET 4'h0
`define DEA_ADDR_BITS_DEF 8
`define DEA_SYNC_STAGES 2
`endif

//--- dea_sync.v
// Purpose: two flop level synchroniser
// Assumes: input from a foreign timer domain
// Notes: first flop only feeds the second
`timescale 1ns/1ps
module dea_sync (
    // Clock and reset
    input wire clk,
    input wire nrst,
    input wire ce,
    // Level
    input wire din,
    output reg dout
);
    reg meta;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
